// ---- src/flash_bus_cycle.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  flash_cycle_if.slave     bus,
  output logic      [21:0] flash_addr,
  output logic      [15:0] flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CY_IDLE = 4'b0001,
    CY_LOW  = 4'b0010,
    CY_HIGH = 4'b0100,
    CY_READ = 4'b1000
  } cy_t;

  typedef struct packed {
    cy_t         st;
    logic [7:0]  cnt;
    logic [21:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic [15:0] dq_s3;
    logic [15:0] rdata;
    logic        ack;
  } cyc_state_t;

  cyc_state_t s;
  cyc_state_t next_s;

  always_comb begin
    next_s       = s;
    next_s.ack   = 1'b0;
    next_s.dq_s1 = flash_dq_in;
    next_s.dq_s2 = s.dq_s1;
    next_s.dq_s3 = s.dq_s2;
    unique case (s.st)
      CY_IDLE: begin
        if (bus.req && !s.ack) begin
          next_s.addr = bus.addr;
          next_s.ce_n = 1'b0;
          if (bus.write) begin
            next_s.we_n   = 1'b0;
            next_s.dq_oe  = 1'b1;
            next_s.dq_out = {8'h00, bus.wdata[7:0]};
            next_s.cnt    = 8'(WP_CYC - 1);
            next_s.st     = CY_LOW;
          end else begin
            next_s.oe_n = 1'b0;
            next_s.cnt  = 8'(ACC_CYC + SYNC_CYC - 1);
            next_s.st   = CY_READ;
          end
        end
      end
      CY_LOW: begin
        if (s.cnt == 8'h00) begin
          // rising write strobe latches data and starts device timers
          next_s.we_n = 1'b1;
          next_s.ce_n = 1'b1;
          next_s.cnt  = 8'(WPH_CYC - 1);
          next_s.st   = CY_HIGH;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      CY_HIGH: begin
        if (s.cnt == 8'h00) begin
          next_s.dq_oe = 1'b0;
          next_s.ack   = 1'b1;
          next_s.st    = CY_IDLE;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      CY_READ: begin
        if (s.cnt != 8'h00) begin
          next_s.cnt = s.cnt - 8'h01;
        end else if (s.dq_s2 == s.dq_s3) begin
          // a bus still settling is sampled again rather than taken
          next_s.rdata = s.dq_s3;
          next_s.oe_n  = 1'b1;
          next_s.ce_n  = 1'b1;
          next_s.ack   = 1'b1;
          next_s.st    = CY_IDLE;
        end
      end
      default: next_s.st = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: CY_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign flash_addr   = s.addr;
  assign flash_dq_out = s.dq_out;
  assign flash_dq_oe  = s.dq_oe;
  assign flash_ce_n   = s.ce_n;
  assign flash_we_n   = s.we_n;
  assign flash_oe_n   = s.oe_n;
  assign bus.ack      = s.ack;
  assign bus.rdata    = s.rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_we_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(flash_we_n) |-> (!flash_we_n)[*5] ##1 flash_we_n)
    else $error("write strobe low time wrong");
  chk_upper_dq_zero: assert property (@(posedge clk) disable iff (!rst_n)
    flash_dq_oe |-> flash_dq_out[15:8] == 8'h00)
    else $error("upper data bits driven nonzero");
  chk_no_drive_read: assert property (@(posedge clk) disable iff (!rst_n)
    !flash_oe_n |-> !flash_dq_oe)
    else $error("data driven during read");

endmodule
`default_nettype wire

// ---- src/flash_cycle_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if;
  logic        req;
  logic        write;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  modport master (output req, write, addr, wdata, input ack, rdata);
  modport slave  (input req, write, addr, wdata, output ack, rdata);
endinterface
`default_nettype wire

// ---- src/flash_erase_host.sv ----
`timescale 1ns/1ps
`default_nettype none
//Function
// - chip erase is six writes: AA@555, 55@2AA, 80@555, AA@555, 55@2AA, 10@555.
// - sector erase is unlock pair, 80, unlock pair, then 30 at sector.
// - host accepts an added sector write only while the window counted down from WINDOW_LIMIT at the previous write's ack is open.
// - host addresses suspend to a bank holding a selected sector; the code sends it to whatever address REG_ADDR holds, unchecked.
// - upper data bits are don't-care in command cycles.
module flash_erase_host
  import flash_host_pkg::*;
#(
  parameter int WINDOW_LIMIT = WINDOW_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [21:0] flash_addr,
  output logic      [15:0] flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n,
  output logic             flash_reset_n,
  input  wire logic        ready_busy_output
);

  // ----------------------------------------------------------------
  // command table
  // ----------------------------------------------------------------
  function automatic logic [2:0] seq_len(cmd_t c);
    unique case (c)
      CMD_CHIP, CMD_SECTOR: seq_len = 3'd6;
      CMD_BYPASS:           seq_len = 3'd2;
      default:              seq_len = 3'd1;
    endcase
  endfunction

  function automatic logic [29:0] seq_word(cmd_t c, logic [2:0] i, logic [21:0] a);
    logic [29:0] w;
    w = {a, 8'h00};
    unique case (c)
      CMD_CHIP, CMD_SECTOR: begin
        unique case (i)
          3'd0, 3'd3: w = {ADDR_UNLOCK1, D_UNLOCK1};
          3'd1, 3'd4: w = {ADDR_UNLOCK2, D_UNLOCK2};
          3'd2:       w = {ADDR_UNLOCK1, D_SETUP};
          default:    w = (c == CMD_CHIP) ? {ADDR_UNLOCK1, D_CHIP} : {a, D_SECTOR};
        endcase
      end
      CMD_ADD:     w = {a, D_SECTOR};
      CMD_SUSPEND: w = {a, D_SUSPEND};
      CMD_RESUME:  w = {a, D_RESUME};
      CMD_RESET:   w = {ADDR_ANY, D_RESET};
      CMD_BYPASS:  w = (i == 3'd0) ? {ADDR_ANY, D_EXIT1} : {ADDR_ANY, D_EXIT2};
      default:     w = {a, 8'h00};
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_WAIT  = 4'b0100,
    ST_HOLD  = 4'b1000
  } st_t;

  typedef struct packed {
    st_t         st;
    cmd_t        cmd;
    logic [2:0]  step;
    logic [21:0] addr;
    logic [21:0] seq_addr;
    logic        hw_rst;
    logic [31:0] win_cnt;
    logic        win_open;
    logic        suspended;
    logic        refused;
    logic [11:0] susp_cnt;
    logic [15:0] rdata;
    logic [2:0]  rb_s;
    logic        ready;
    logic        req;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        pin_rst_n;
  } host_state_t;

  host_state_t s;
  host_state_t next_s;
  logic [29:0] word;
  cmd_t        wcmd;
  logic        last;

  flash_cycle_if bus ();

  assign word      = seq_word(s.cmd, s.step, s.seq_addr);
  assign bus.req   = s.req;
  assign bus.write = (s.cmd != CMD_READ);
  assign bus.addr  = word[29:8];
  assign bus.wdata = {8'h00, word[7:0]};
  assign wcmd      = cmd_t'(pwdata[3:0]);
  assign last      = (s.step == seq_len(s.cmd) - 3'd1);

  always_comb begin
    next_s         = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.rb_s    = {s.rb_s[1:0], ready_busy_output};
    if (s.rb_s[1] == s.rb_s[2]) begin
      next_s.ready = s.rb_s[2];
    end
    // ---------------- loading window timer ----------------
    if (s.win_open) begin
      if (s.win_cnt == 32'h0) begin
        next_s.win_open = 1'b0;
      end else begin
        next_s.win_cnt = s.win_cnt - 32'h1;
      end
    end
    // ---------------- sequencer ----------------
    unique case (s.st)
      ST_IDLE: ;
      ST_ISSUE: begin
        next_s.req = 1'b1;
        next_s.st  = ST_WAIT;
      end
      ST_WAIT: begin
        if (bus.ack) begin
          next_s.req = 1'b0;
          if (s.cmd == CMD_READ) begin
            next_s.rdata = bus.rdata;
          end
          if (!last) begin
            next_s.step = s.step + 3'd1;
            next_s.st   = ST_ISSUE;
          end else if (s.cmd == CMD_SECTOR || s.cmd == CMD_ADD) begin
            // window counts from the cycle ack, which comes WPH_CYC cycles after the strobe rise that closed this write
            next_s.win_open = 1'b1;
            next_s.win_cnt  = 32'(WINDOW_LIMIT);
            next_s.st       = ST_IDLE;
          end else if (s.cmd == CMD_SUSPEND) begin
            // worst-case suspend latency before the bank may be used
            next_s.win_open = 1'b0;
            next_s.susp_cnt = 12'(SUSP_CYC - 1);
            next_s.st       = ST_HOLD;
          end else begin
            if (s.cmd == CMD_RESUME) begin
              next_s.suspended = 1'b0;
            end
            next_s.st = ST_IDLE;
          end
        end
      end
      ST_HOLD: begin
        if (s.susp_cnt == 12'h000) begin
          next_s.suspended = 1'b1;
          next_s.st        = ST_IDLE;
        end else begin
          next_s.susp_cnt = s.susp_cnt - 12'h001;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    // ---------------- apb slave ----------------
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0;
      if (pwrite) begin
        unique case (paddr)
          REG_CTRL: begin
            next_s.hw_rst = pwdata[CTRL_RST_BIT];
            if (pwdata[CTRL_RST_BIT]) begin
              // hardware reset aborts any erase in the device
              next_s.win_open  = 1'b0;
              next_s.suspended = 1'b0;
              if (s.st == ST_HOLD) begin
                next_s.st = ST_IDLE;
              end
            end
            if (wcmd != CMD_NONE) begin
              if (s.st != ST_IDLE || s.hw_rst || wcmd > CMD_READ
                  || (wcmd == CMD_ADD && !s.win_open)
                  || (wcmd == CMD_RESUME && !s.suspended)) begin
                next_s.refused = 1'b1;
              end else begin
                next_s.refused  = 1'b0;
                next_s.cmd      = wcmd;
                next_s.step     = 3'd0;
                next_s.seq_addr = s.addr;
                next_s.st       = ST_ISSUE;
                // any command but an add or a read cancels the pending sector set
                if (wcmd != CMD_ADD && wcmd != CMD_SUSPEND && wcmd != CMD_READ) begin
                  next_s.win_open = 1'b0;
                end
                if (wcmd == CMD_SUSPEND) begin
                  next_s.win_open = 1'b0;
                end
              end
            end
          end
          REG_ADDR: next_s.addr = pwdata[21:0];
          default:  next_s.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          REG_CTRL:   next_s.prdata = {23'h0, s.hw_rst, 4'h0, s.cmd};
          REG_ADDR:   next_s.prdata = {10'h0, s.addr};
          REG_STATUS: next_s.prdata = {27'h0, s.suspended, s.refused, s.ready, s.win_open,
                                       (s.st != ST_IDLE)};
          REG_RDATA:  next_s.prdata = {16'h0, s.rdata};
          default:    next_s.pslverr = 1'b1;
        endcase
      end
    end
    next_s.pin_rst_n = !next_s.hw_rst;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: ST_IDLE, cmd: CMD_NONE, ready: 1'b1, rb_s: 3'b111, pin_rst_n: 1'b1,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign flash_reset_n = s.pin_rst_n;

  flash_bus_cycle u_cycle (
    .clk          (clk),
    .rst_n        (rst_n),
    .bus          (bus),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in),
    .flash_ce_n   (flash_ce_n),
    .flash_we_n   (flash_we_n),
    .flash_oe_n   (flash_oe_n)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_sector_done;
    bus.ack && s.st == ST_WAIT && s.cmd == CMD_SECTOR && last;
  endsequence
  sequence s_exit_first;
    bus.ack && s.cmd == CMD_BYPASS && s.step == 3'd0;
  endsequence

  chk_chip_final: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.req && s.cmd == CMD_CHIP && s.step == 3'd5)
      |-> bus.addr == ADDR_UNLOCK1 && bus.wdata[7:0] == D_CHIP)
    else $error("chip erase final cycle wrong");
  chk_sector_final: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.req && s.cmd == CMD_SECTOR && s.step == 3'd5)
      |-> bus.addr == s.seq_addr && bus.wdata[7:0] == D_SECTOR)
    else $error("sector erase final cycle wrong");
  chk_window_opens: assert property (@(posedge clk) disable iff (!rst_n)
    s_sector_done |=> s.win_open && s.win_cnt == 32'(WINDOW_LIMIT))
    else $error("window not opened after sector erase");
  chk_add_refused: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && penable && !s.pready && pwrite && paddr == REG_CTRL
      && wcmd == CMD_ADD && !s.win_open) |=> s.refused && s.cmd == $past(s.cmd))
    else $error("late sector add not refused");
  chk_suspend_word: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.req && s.cmd == CMD_SUSPEND) |-> bus.wdata[7:0] == D_SUSPEND && !s.win_open)
    else $error("suspend cycle wrong");
  chk_reset_single: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.ack && s.cmd == CMD_RESET) |=> s.st == ST_IDLE && !s.req)
    else $error("reset command not single cycle");
  chk_exit_pair: assert property (@(posedge clk) disable iff (!rst_n)
    s_exit_first |-> ##[1:40] (bus.req && bus.wdata[7:0] == D_EXIT2))
    else $error("bypass exit second cycle missing");

endmodule
`default_nettype wire

// ---- src/flash_host_pkg.sv ----
package flash_host_pkg;

  // ----------------------------------------------------------------
  // clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 125;
  localparam int T_WP_NS      = 35;
  localparam int T_WPH_NS     = 20;
  localparam int T_ACC_NS     = 70;
  localparam int T_WINDOW_US  = 80;
  localparam int T_SUSP_US    = 20;
  localparam int SYNC_CYC     = 3;
  // least times round up, the loading window (a longest time) rounds down
  localparam int WP_CYC       = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPH_CYC      = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC      = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int WINDOW_CYC   = T_WINDOW_US * CLK_MHZ;
  localparam int SUSP_CYC     = T_SUSP_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // flash command cycles
  // ----------------------------------------------------------------
  localparam logic [21:0] ADDR_UNLOCK1 = 22'h000555;
  localparam logic [21:0] ADDR_UNLOCK2 = 22'h0002AA;
  localparam logic [21:0] ADDR_ANY     = 22'h000000;
  localparam logic [7:0]  D_UNLOCK1    = 8'hAA;
  localparam logic [7:0]  D_UNLOCK2    = 8'h55;
  localparam logic [7:0]  D_SETUP      = 8'h80;
  localparam logic [7:0]  D_CHIP       = 8'h10;
  localparam logic [7:0]  D_SECTOR     = 8'h30;
  localparam logic [7:0]  D_SUSPEND    = 8'hB0;
  localparam logic [7:0]  D_RESUME     = 8'h30;
  localparam logic [7:0]  D_RESET      = 8'hF0;
  localparam logic [7:0]  D_EXIT1      = 8'h90;
  localparam logic [7:0]  D_EXIT2      = 8'h00;

  // ----------------------------------------------------------------
  // own register map (apb, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_ADDR     = 12'h004;
  localparam logic [11:0] REG_STATUS   = 12'h008;
  localparam logic [11:0] REG_RDATA    = 12'h00C;
  localparam int          CTRL_RST_BIT = 8;
  localparam int          ST_BUSY      = 0;
  localparam int          ST_WINDOW    = 1;
  localparam int          ST_READY     = 2;
  localparam int          ST_REFUSED   = 3;
  localparam int          ST_SUSP      = 4;

  typedef enum logic [3:0] {
    CMD_NONE    = 4'h0,
    CMD_CHIP    = 4'h1,
    CMD_SECTOR  = 4'h2,
    CMD_ADD     = 4'h3,
    CMD_SUSPEND = 4'h4,
    CMD_RESUME  = 4'h5,
    CMD_RESET   = 4'h6,
    CMD_BYPASS  = 4'h7,
    CMD_READ    = 4'h8
  } cmd_t;

endpackage

// ---- tb/flash_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter int ERASE_CYC = 150
) (
  input  wire logic        clk,
  input  wire logic [21:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_dq_oe,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_reset_n,
  output logic      [15:0] flash_dq_in,
  output logic             ready_busy_output
);
  logic [37:0] got_q[$];
  logic [47:0] hist      = '0;
  logic [15:0] junk      = 16'hA5A5;
  int          busy_left = 0;

  // ----------------------------------------------------------------
  // write capture and command decode
  // ----------------------------------------------------------------
  // oe guard: strobes leaving x at time zero must not look like a write
  always @(posedge flash_we_n) begin
    if (flash_dq_oe === 1'b1) begin
      got_q.push_back({flash_addr, flash_dq_out});
      hist = {hist[39:0], flash_dq_out[7:0]};
      // only six matching writes in a row start an erase
      if (busy_left == 0 && (hist == 48'hAA5580AA5510 || hist == 48'hAA5580AA5530)) begin
        busy_left = ERASE_CYC;
      end
      if (flash_dq_out[7:0] == 8'hB0) begin
        busy_left = 0;
      end
    end
  end

  // ----------------------------------------------------------------
  // embedded erase timer, abort and pins
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    junk <= ~junk;
    if (!flash_reset_n) begin
      busy_left <= 0;
    end else if (busy_left > 0) begin
      busy_left <= busy_left - 1;
    end
  end

  // pull-up when released; data lines show a changing pattern when not read
  assign ready_busy_output = (busy_left == 0);
  // while erasing only status (polling bit low) comes back, never array data
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ?
                       ((busy_left != 0) ? 16'h0000 : (flash_addr[15:0] ^ 16'h5A3C)) : junk;
endmodule
`default_nettype wire

// ---- tb/tb_flash_erase_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_flash_erase_host;
  import flash_host_pkg::*;
  localparam int WIN = 50;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [21:0] flash_addr, sa, sb;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic        flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, rdy;
  logic [37:0] exp_q[$];
  logic [37:0] g;
  int          n_errors, n_checks, seed;

  flash_erase_host #(.WINDOW_LIMIT(WIN)) dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_reset_n(flash_reset_n),
    .ready_busy_output(rdy));
  flash_dev_model model (.clk(clk), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_reset_n(flash_reset_n), .flash_dq_in(flash_dq_in),
    .ready_busy_output(rdy));

  // ----------------------------------------------------------------
  // compare and closing
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // every flash write seen by the model against the expected queue
  task automatic chk_cyc();
    chk_reg(32'(model.got_q.size()), 32'(exp_q.size()));
    while (exp_q.size() > 0 && model.got_q.size() > 0) begin
      g = model.got_q.pop_front();
      n_checks++;
      if (g !== exp_q[0]) begin
        n_errors++;
        $display("mismatch at %0t: got %h expected %h", $time, g, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
    exp_q.delete();
    model.got_q.delete();
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // apb master and helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [21:0] a, input logic [3:0] c);
    apb(1'b1, REG_ADDR, {10'h000, a});
    apb(1'b1, REG_CTRL, {28'h0000000, c});
  endtask

  // polling bound covers the long hold after a suspend
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[b] !== v && n < 1000);
    chk_reg({31'h0, rd[b]}, {31'h0, v});
  endtask

  function automatic logic [37:0] e(input logic [21:0] a, input logic [7:0] d);
    return {a, 8'h00, d};
  endfunction

  task automatic seq6(input logic [21:0] a, input logic [7:0] d);
    exp_q.push_back(e(ADDR_UNLOCK1, D_UNLOCK1));
    exp_q.push_back(e(ADDR_UNLOCK2, D_UNLOCK2));
    exp_q.push_back(e(ADDR_UNLOCK1, D_SETUP));
    exp_q.push_back(e(ADDR_UNLOCK1, D_UNLOCK1));
    exp_q.push_back(e(ADDR_UNLOCK2, D_UNLOCK2));
    exp_q.push_back(e(a, d));
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, scenarios
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    n_errors = 0;
    n_checks = 0;
    seed = 32'h9D5C9DAB;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    chk_reg(rd, 32'h00000004);
    apb(1'b0, 12'h010, 32'h0);
    chk_reg({31'h0, er}, 32'h1);
    // chip erase, then hardware reset aborts the embedded erase
    seq6(ADDR_UNLOCK1, D_CHIP);
    cmd(22'h000000, CMD_CHIP);
    wait_st(ST_BUSY, 1'b0);
    chk_reg({31'h0, rd[ST_READY]}, 32'h0);
    chk_cyc();
    apb(1'b1, REG_CTRL, 32'h00000100);
    chk_reg({31'h0, flash_reset_n}, 32'h0);
    wait_st(ST_READY, 1'b1);
    apb(1'b1, REG_CTRL, 32'h0);
    // sector erase with one sector added inside the loading window
    sa = 22'($random(seed));
    sb = 22'($random(seed));
    seq6(sa, D_SECTOR);
    cmd(sa, CMD_SECTOR);
    wait_st(ST_BUSY, 1'b0);
    chk_reg({31'h0, rd[ST_WINDOW]}, 32'h1);
    exp_q.push_back(e(sb, D_SECTOR));
    cmd(sb, CMD_ADD);
    wait_st(ST_BUSY, 1'b0);
    chk_cyc();
    wait_st(ST_WINDOW, 1'b0);
    cmd(sb, CMD_ADD);
    apb(1'b0, REG_STATUS, 32'h0);
    chk_reg({31'h0, rd[ST_REFUSED]}, 32'h1);
    // suspend, read while suspended, resume twice
    exp_q.push_back(e(sa, D_SUSPEND));
    cmd(sa, CMD_SUSPEND);
    wait_st(ST_SUSP, 1'b1);
    cmd(sb, CMD_READ);
    wait_st(ST_BUSY, 1'b0);
    apb(1'b0, REG_RDATA, 32'h0);
    chk_reg(rd, {16'h0000, sb[15:0] ^ 16'h5A3C});
    exp_q.push_back(e(sa, D_RESUME));
    cmd(sa, CMD_RESUME);
    wait_st(ST_SUSP, 1'b0);
    apb(1'b1, REG_CTRL, {28'h0000000, CMD_RESUME});
    apb(1'b0, REG_STATUS, 32'h0);
    chk_reg({31'h0, rd[ST_REFUSED]}, 32'h1);
    chk_cyc();
    // a reset written inside the loading window closes it early
    seq6(sb, D_SECTOR);
    exp_q.push_back(e(ADDR_ANY, D_RESET));
    cmd(sb, CMD_SECTOR);
    wait_st(ST_BUSY, 1'b0);
    apb(1'b1, REG_CTRL, {28'h0000000, CMD_RESET});
    wait_st(ST_BUSY, 1'b0);
    chk_reg({31'h0, rd[ST_WINDOW]}, 32'h0);
    chk_cyc();
    // single reset write, then the two-write bypass exit
    exp_q.push_back(e(ADDR_ANY, D_RESET));
    exp_q.push_back(e(ADDR_ANY, D_EXIT1));
    exp_q.push_back(e(ADDR_ANY, D_EXIT2));
    apb(1'b1, REG_CTRL, {28'h0000000, CMD_RESET});
    wait_st(ST_BUSY, 1'b0);
    apb(1'b1, REG_CTRL, {28'h0000000, CMD_BYPASS});
    wait_st(ST_BUSY, 1'b0);
    chk_cyc();
    wrap_up();
  end
endmodule
`default_nettype wire
